//--- hw/srs_map.svh
// constants of the smbus register slave: addresses, field positions, timing
// assumes a 25 MHz system clock; included by the top module only
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH

// ----------------------------------------------------------------------------
// protocol constants
// ----------------------------------------------------------------------------
`define SRS_ARA_ADDR 7'h0c
`define SRS_RW_BIT 0
`define SRS_BYTE_BITS 4'h8
`define SRS_PTR_RST 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SRS_TMO_MS 30
`define SRS_CLK_KHZ 25000
`define SRS_TMO_CYC (`SRS_TMO_MS * `SRS_CLK_KHZ)

`endif

//--- hw/srs_pkg.sv
// types shared by the smbus register slave and its testbench
// assumes nothing of its surroundings
`default_nettype none
package srs_pkg;

  // ----------------------------------------------------------------------------
  // slave protocol states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_RX,
    ST_RACK,
    ST_TX,
    ST_HACK
  } srs_state_t;

  // register space port: pointer, write strobe and data travel together
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } srs_reg_t;

  // open-drain pin, level driven and enable
  typedef struct packed {
    logic o;
    logic oe;
  } srs_pin_t;

  // whole slave context, registered as one
  typedef struct packed {
    srs_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic ara;
    logic idx_first;
    logic [7:0] ptr;
    logic we;
    logic [7:0] wdata;
    logic sda_oe;
    logic mask;
    logic alert_oe;
  } srs_ctx_t;

endpackage
`default_nettype wire

//--- hw/srs_register_slave.sv
// smbus slave engine giving a host byte access to a register space
// assumes: host drives scl at most 400 kHz, register file answers reg_rdata
// combinationally for reg_port.addr on this clock, slave_addr is static
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.svh"
module srs_register_slave #(
  parameter int TMO_CYC = `SRS_TMO_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output srs_pkg::srs_pin_t sda_pin,
  output srs_pkg::srs_pin_t alert_pin,
  input wire logic [6:0] slave_addr,
  input wire logic int_pending,
  input wire logic timeout_disable_bit,
  output srs_pkg::srs_reg_t reg_port,
  input wire logic [7:0] reg_rdata,
  output logic alert_masked
);

  localparam int TW = $clog2(TMO_CYC + 1);

  logic [1:0] rst_r;
  logic rst_n;
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_p_r, sda_p_r;
  logic scl_rise, scl_fall, start_c, stop_c, tmo_hit;
  logic hit_own, hit_ara;
  logic [TW-1:0] tmo_r, tmo_nxt;
  logic [7:0] tx_byte;
  srs_pkg::srs_ctx_t c, n;

  // ----------------------------------------------------------------------------
  // reset release and pin sampling
  // ----------------------------------------------------------------------------
  // reset enters asynchronously but is released on the clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_r <= 2'h0;
    end else begin
      rst_r <= {rst_r[0], 1'b1};
    end
  end
  assign rst_n = rst_r[1];

  srs_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // previous sample for edge and condition detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  // start and stop are sda edges while scl stays high
  assign scl_rise = scl_s & ~scl_p_r;
  assign scl_fall = ~scl_s & scl_p_r;
  assign start_c = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_c = scl_s & scl_p_r & ~sda_p_r & sda_s;

  // ----------------------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------------------
  // alert address only counts while the alert pin is really pulled
  assign hit_own = (c.sh[7:1] == slave_addr);
  assign hit_ara = (c.sh[7:1] == `SRS_ARA_ADDR) && c.sh[`SRS_RW_BIT] && c.alert_oe;
  // alert response returns the own address, otherwise the pointed register
  assign tx_byte = c.ara ? {slave_addr, 1'b0} : reg_rdata;

  // ----------------------------------------------------------------------------
  // inactivity timer
  // ----------------------------------------------------------------------------
  // any pin movement restarts it; saturates so it never wraps into a miss
  always_comb begin
    tmo_nxt = tmo_r;
    if (scl_s != scl_p_r || sda_s != sda_p_r || c.st == srs_pkg::ST_IDLE) begin
      tmo_nxt = '0;
    end else if (tmo_r != TW'(TMO_CYC)) begin
      tmo_nxt = tmo_r + TW'(1);
    end
  end
  assign tmo_hit = (tmo_r == TW'(TMO_CYC)) && !timeout_disable_bit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // slave protocol machine
  // ----------------------------------------------------------------------------
  // bits are sampled on scl rise and driven on scl fall; never stretches scl
  always_comb begin
    n = c;
    n.we = 1'b0;
    // pointer steps after the write strobe so the strobe sees the old index
    if (c.we) begin
      n.ptr = c.ptr + 8'h01;
    end
    // mask rearms once the interrupt source goes quiet
    if (!int_pending) begin
      n.mask = 1'b0;
    end
    n.alert_oe = int_pending & ~c.mask;
    if (stop_c || tmo_hit) begin
      n.st = srs_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.st = srs_pkg::ST_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
      n.idx_first = 1'b1;
      n.ara = 1'b0;
    end else begin
      case (c.st)
        srs_pkg::ST_ADDR: begin
          if (scl_rise) begin
            n.sh = {c.sh[6:0], sda_s};
            n.cnt = c.cnt + 4'h1;
          end else if (scl_fall && c.cnt == `SRS_BYTE_BITS) begin
            if (hit_own || hit_ara) begin
              n.sda_oe = 1'b1;
              n.st = srs_pkg::ST_AACK;
              n.rw = c.sh[`SRS_RW_BIT];
              n.ara = hit_ara & ~hit_own;
            end else begin
              n.st = srs_pkg::ST_IDLE;
            end
          end
        end
        srs_pkg::ST_AACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (c.rw) begin
              n.sda_oe = ~tx_byte[7];
              n.sh = {tx_byte[6:0], 1'b0};
              n.st = srs_pkg::ST_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.st = srs_pkg::ST_RX;
            end
          end
        end
        srs_pkg::ST_RX: begin
          if (scl_rise) begin
            n.sh = {c.sh[6:0], sda_s};
            n.cnt = c.cnt + 4'h1;
          end else if (scl_fall && c.cnt == `SRS_BYTE_BITS) begin
            n.sda_oe = 1'b1;
            n.st = srs_pkg::ST_RACK;
            if (c.idx_first) begin
              n.ptr = c.sh;
              n.idx_first = 1'b0;
            end else begin
              n.we = 1'b1;
              n.wdata = c.sh;
            end
          end
        end
        srs_pkg::ST_RACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.st = srs_pkg::ST_RX;
          end
        end
        srs_pkg::ST_TX: begin
          if (scl_rise) begin
            // released a one but the wire is low: someone else won
            if (!c.sda_oe && !sda_s) begin
              n.st = srs_pkg::ST_IDLE;
            end else begin
              n.cnt = c.cnt + 4'h1;
            end
          end else if (scl_fall) begin
            if (c.cnt == `SRS_BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.st = srs_pkg::ST_HACK;
            end else begin
              n.sda_oe = ~c.sh[7];
              n.sh = {c.sh[6:0], 1'b0};
            end
          end
        end
        srs_pkg::ST_HACK: begin
          if (scl_rise) begin
            if (c.ara) begin
              n.mask = 1'b1;
              n.st = srs_pkg::ST_IDLE;
            end else if (sda_s) begin
              n.st = srs_pkg::ST_IDLE;
            end else begin
              n.ptr = c.ptr + 8'h01;
              n.st = srs_pkg::ST_AACK;
            end
          end
        end
        default: begin
          n.sda_oe = 1'b0;
          n.st = srs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '{st: srs_pkg::ST_IDLE, sh: 8'h00, cnt: 4'h0, rw: 1'b0, ara: 1'b0,
             idx_first: 1'b1, ptr: `SRS_PTR_RST, we: 1'b0, wdata: 8'h00,
             sda_oe: 1'b0, mask: 1'b0, alert_oe: 1'b0};
    end else begin
      c <= n;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all straight from the context flops
  // ----------------------------------------------------------------------------
  assign sda_pin = '{o: 1'b0, oe: c.sda_oe};
  assign alert_pin = '{o: 1'b0, oe: c.alert_oe};
  assign reg_port = '{we: c.we, addr: c.ptr, data: c.wdata};
  assign alert_masked = c.mask;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_addr_ack:
    assert property (c.st == srs_pkg::ST_ADDR && scl_fall && c.cnt == 4'h8 && hit_own
      && !stop_c && !start_c && !tmo_hit |=> c.sda_oe && c.st == srs_pkg::ST_AACK)
    else $error("own address not acknowledged");
  a_foreign_quiet:
    assert property (c.st == srs_pkg::ST_ADDR && scl_fall && c.cnt == 4'h8 && !hit_own
      && !hit_ara |=> !c.sda_oe && c.st == srs_pkg::ST_IDLE)
    else $error("foreign address touched the bus");
  a_ara_gate:
    assert property (c.st == srs_pkg::ST_ADDR && c.sh[7:1] == `SRS_ARA_ADDR && !c.alert_oe
      && c.sh[7:1] != slave_addr ##1 c.st == srs_pkg::ST_AACK |-> 1'b0)
    else $error("alert address answered with alert idle");
  a_stop_reset:
    assert property (stop_c |=> c.st == srs_pkg::ST_IDLE ##1 !sda_pin.oe)
    else $error("stop did not reset the slave");
  a_timeout_reset:
    assert property (tmo_r == TW'(TMO_CYC) && !timeout_disable_bit
      |=> c.st == srs_pkg::ST_IDLE && !c.sda_oe)
    else $error("inactivity timeout ignored");
  a_index_load:
    assert property (c.st == srs_pkg::ST_RX && c.idx_first && scl_fall && c.cnt == 4'h8
      && !stop_c && !start_c && !tmo_hit |=> c.ptr == $past(c.sh) && !c.we)
    else $error("index byte did not load pointer");
  a_write_step:
    assert property (reg_port.we |=> reg_port.addr == $past(reg_port.addr) + 8'h01)
    else $error("block write pointer did not step");
  a_nack_hold:
    assert property (c.st == srs_pkg::ST_HACK && scl_rise && sda_s && !c.ara
      && !stop_c && !start_c && !tmo_hit |=> $stable(c.ptr) [*2])
    else $error("pointer advanced on nack");
  a_lost_bit_abort:
    assert property (c.st == srs_pkg::ST_TX && scl_rise && !c.sda_oe && !sda_s
      && !stop_c && !start_c && !tmo_hit |=> c.st == srs_pkg::ST_IDLE && !c.mask)
    else $error("lost arbitration not abandoned");
  a_mask_release:
    assert property (c.st == srs_pkg::ST_HACK && c.ara && scl_rise && int_pending
      && !stop_c && !start_c && !tmo_hit |=> c.mask ##1 !alert_pin.oe)
    else $error("alert not released after response");

endmodule
`default_nettype wire

//--- hw/srs_sync.sv
// two flip-flop synchroniser for bus pins
// assumes inputs come from outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module srs_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- tb/srs_host_model.sv
// smbus host model: drives scl and sda towards the register slave
// assumes pull-ups on both lines; one bit takes 8 clk (320 ns)
`timescale 1ns/1ps
`default_nettype none
module srs_host_model (
  input wire logic clk,
  input wire logic dev_pull,
  output logic scl,
  output wire logic sda
);
  logic host_sda;

  // wired-and with pull-up: a released line reads high
  assign sda = host_sda & ~dev_pull;

  initial begin
    scl = 1'b1;
    host_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------------------
  // sda falls while scl is high; extra low time lets the slave release first
  task automatic start();
    host_sda <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    host_sda <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  // sda rises while scl is high; scl then stays high, no free-running clock
  task automatic stop();
    host_sda <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    host_sda <= 1'b1;
    tick(8);
  endtask

  // data changes only while scl is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    host_sda <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask

  // eight bits msb first, then the ack slot; a 1 sent means released
  task automatic byte_io(input logic [7:0] tx, input logic ackbit, output logic [7:0] rx,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ackbit, ack);
  endtask
endmodule
`default_nettype wire

//--- tb/srs_register_slave_bench.sv
// testbench of the smbus register slave, self-checking
// assumes the host model beside it and a register file modelled here
`timescale 1ns/1ps
`default_nettype none
module srs_register_slave_bench;
  localparam logic [7:0] AW = 8'h58;
  localparam logic [7:0] AR = 8'h59;
  localparam logic [7:0] ARA = 8'h19;
  logic clk, nrst, int_pending, tmo_dis, alert_masked;
  logic [6:0] slave_addr;
  wire logic scl, sda;
  wire logic [7:0] rdata;
  srs_pkg::srs_pin_t sda_pin, alert_pin;
  srs_pkg::srs_reg_t reg_port;
  logic [7:0] regs [256];
  int fail_count, comparisons, wr_count;

  srs_register_slave #(.TMO_CYC(200)) u_dut (.clk(clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_pin(sda_pin), .alert_pin(alert_pin), .slave_addr(slave_addr),
    .int_pending(int_pending), .timeout_disable_bit(tmo_dis), .reg_port(reg_port),
    .reg_rdata(rdata), .alert_masked(alert_masked));
  srs_host_model u_host (.clk(clk), .dev_pull(sda_pin.oe), .scl(scl), .sda(sda));

  // register file: combinational read, write on the strobe
  assign rdata = regs[reg_port.addr];
  always @(posedge clk) begin
    if (reg_port.we === 1'b1) begin
      regs[reg_port.addr] <= reg_port.data;
      wr_count++;
    end
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic a;
    u_host.byte_io(b, 1'b1, rx, a);
    chk("ack", {7'h0, exp_ack}, {7'h0, a});
  endtask

  task automatic recv(input logic [7:0] exp, input logic nack);
    logic [7:0] rx;
    logic a;
    u_host.byte_io(8'hff, nack, rx, a);
    chk("read data", exp, rx);
  endtask

  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_write_read();
    u_host.start();
    send(AW, 1'b0);
    send(8'h10, 1'b0);
    send(8'ha5, 1'b0);
    u_host.stop();
    chk("reg 10", 8'ha5, regs[8'h10]);
    u_host.start();
    send(AW, 1'b0);
    send(8'h10, 1'b0);
    u_host.start();
    send(AR, 1'b0);
    recv(8'ha5, 1'b1);
    u_host.stop();
  endtask

  // index only, then two reads without index: same register, no writes
  task automatic t_pointer();
    int n;
    n = wr_count;
    u_host.start();
    send(AW, 1'b0);
    send(8'h20, 1'b0);
    u_host.stop();
    repeat (2) begin
      u_host.start();
      send(AR, 1'b0);
      recv(8'h20 ^ 8'h5a, 1'b1);
      u_host.stop();
    end
    chk("write count", n[7:0], wr_count[7:0]);
  endtask

  task automatic t_block();
    u_host.start();
    send(AW, 1'b0);
    send(8'h30, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    u_host.stop();
    chk("reg 33", 8'h33 ^ 8'h5a, regs[8'h33]);
    u_host.start();
    send(AW, 1'b0);
    send(8'h2f, 1'b0);
    u_host.start();
    send(AR, 1'b0);
    recv(8'h2f ^ 8'h5a, 1'b0);
    recv(8'h11, 1'b0);
    recv(8'h22, 1'b0);
    recv(8'h33, 1'b1);
    u_host.stop();
  endtask

  // foreign address and alert address while no alert is raised
  task automatic t_refuse();
    u_host.start();
    send({7'h2d, 1'b0}, 1'b1);
    u_host.stop();
    u_host.start();
    send(ARA, 1'b1);
    u_host.stop();
  endtask

  task automatic t_alert();
    logic [7:0] rx;
    logic a;
    int_pending <= 1'b1;
    u_host.tick(4);
    chk("alert drive", 8'h1, {7'h0, alert_pin.oe});
    u_host.start();
    send(ARA, 1'b0);
    recv({slave_addr, 1'b0}, 1'b1);
    u_host.stop();
    chk("mask", 8'h1, {7'h0, alert_masked});
    chk("alert drive", 8'h0, {7'h0, alert_pin.oe});
    int_pending <= 1'b0;
    u_host.tick(4);
    // a quiet interrupt source rearms the mask for the next event
    chk("mask rearm", 8'h0, {7'h0, alert_masked});
    int_pending <= 1'b1;
    u_host.tick(4);
    // host pulls the second address bit low where the slave sends a 1
    u_host.start();
    send(ARA, 1'b0);
    u_host.byte_io(8'hbf, 1'b1, rx, a);
    u_host.stop();
    chk("lost byte", 8'h3f, rx);
    chk("mask", 8'h0, {7'h0, alert_masked});
    chk("alert drive", 8'h1, {7'h0, alert_pin.oe});
    int_pending <= 1'b0;
  endtask

  // scl held low through the ack slot; the ack is dropped unless disabled
  task automatic t_timeout(input logic dis);
    logic r;
    tmo_dis <= dis;
    u_host.start();
    for (int i = 7; i >= 0; i--) begin
      u_host.bit_io(AW[i], r);
    end
    u_host.tick(300);
    chk("ack drive", {7'h0, dis}, {7'h0, sda_pin.oe});
    u_host.bit_io(1'b1, r);
    u_host.stop();
  endtask

  // ----------------------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    int_pending = 1'b0;
    tmo_dis = 1'b0;
    slave_addr = 7'h2c;
    for (int i = 0; i < 256; i++) begin
      regs[i] = i[7:0] ^ 8'h5a;
    end
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    t_write_read();
    t_pointer();
    t_block();
    t_refuse();
    t_alert();
    t_timeout(1'b0);
    t_timeout(1'b1);
    finish_test();
  end

  // the sequence needs about 3400 clk; a hang stops well beyond that
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
